/* pkg/dps_defs.svh */
// offsets, field positions, reset values and counts for the diskette phase sequencer
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

// io addresses, primary and secondary sets
`define DPS_MAIN_STATUS_PRI 16'h03F4
`define DPS_MAIN_STATUS_SEC 16'h0374
`define DPS_DATA_PRI 16'h03F5
`define DPS_DATA_SEC 16'h0375

// main status register fields
`define DPS_MSR_RQM 7
`define DPS_MSR_DIO 6
`define DPS_MSR_NDMA 5
`define DPS_MSR_BUSY 4
`define DPS_MSR_RESET 8'h00
`define DPS_RDATA_RESET 8'h00

// command codes (low five bits of the first byte)
`define DPS_OP_SPECIFY 5'h03
`define DPS_OP_SENSE_DRIVE 5'h04
`define DPS_OP_WRITE_DATA 5'h05
`define DPS_OP_READ_DATA 5'h06
`define DPS_OP_RECAL 5'h07
`define DPS_OP_SENSE_INT 5'h08
`define DPS_OP_SEEK 5'h0F

// first result byte values
`define DPS_ST_OK 8'h00
`define DPS_ST_INVALID 8'h80

// sizes and counts
`define DPS_MAX_PARAMS 8
`define DPS_MAX_RESULTS 7
`define DPS_XFER_BYTES 10'd512

`endif

/* pkg/dps_pkg.sv */
// types shared by the diskette phase sequencer
package dps_pkg;

  // gray order along idle -> command -> execution -> results
  typedef enum logic [1:0] {
    DPS_IDLE = 2'b00,
    DPS_CMD = 2'b01,
    DPS_EXEC = 2'b11,
    DPS_RES = 2'b10
  } dps_phase_t;

  typedef enum logic [1:0] {
    DPS_K_INTERNAL = 2'b00,
    DPS_K_MECH = 2'b01,
    DPS_K_DMA_RD = 2'b10,
    DPS_K_DMA_WR = 2'b11
  } dps_kind_t;

endpackage

/* hw/dps_cmd_table.sv */
// command byte decode: parameter count, result count and execution kind
`timescale 1ns/1ps
`include "dps_defs.svh"

module dps_cmd_table (
  // command byte
  input wire logic [7:0] i_code,
  // decoded shape
  output logic [3:0] o_nparam,
  output logic [2:0] o_nres,
  output dps_pkg::dps_kind_t o_kind,
  output logic o_valid
);

  wire [4:0] op = i_code[4:0];

  always_comb begin
    o_nparam = 4'h0;
    o_nres = 3'h1;
    o_kind = dps_pkg::DPS_K_INTERNAL;
    o_valid = 1'b1;
    case (op)
      `DPS_OP_SPECIFY: begin
        o_nparam = 4'h2;
        o_nres = 3'h0;
      end
      `DPS_OP_SENSE_DRIVE: begin
        o_nparam = 4'h1;
      end
      `DPS_OP_WRITE_DATA: begin
        o_nparam = 4'h8;
        o_nres = 3'h7;
        o_kind = dps_pkg::DPS_K_DMA_WR;
      end
      `DPS_OP_READ_DATA: begin
        o_nparam = 4'h8;
        o_nres = 3'h7;
        o_kind = dps_pkg::DPS_K_DMA_RD;
      end
      `DPS_OP_RECAL: begin
        o_nparam = 4'h1;
        o_nres = 3'h0;
        o_kind = dps_pkg::DPS_K_MECH;
      end
      `DPS_OP_SENSE_INT: begin
        o_nres = 3'h2;
      end
      `DPS_OP_SEEK: begin
        o_nparam = 4'h2;
        o_nres = 3'h0;
        o_kind = dps_pkg::DPS_K_MECH;
      end
      default: begin
        // unknown code: no parameters, one status byte flags it
        o_valid = 1'b0;
      end
    endcase
  end

endmodule // dps_cmd_table

/* hw/dps_phase_seq.sv */
// diskette controller phase sequencer: io port registers, phases, dma handshake
`timescale 1ns/1ps
`include "dps_defs.svh"

module dps_phase_seq (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // host io port, synchronous to i_mclk
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  output logic [7:0] o_io_rdata,
  // dma channel two, synchronous to i_mclk
  output logic o_dma_request_ch_two,
  input wire logic i_dma_ack_ch_two_n,
  // drive side
  output logic o_drv_start,
  output logic o_drv_wstrobe,
  output logic [7:0] o_drv_wdata,
  input wire logic [7:0] i_drv_rdata,
  input wire logic i_drv_done,
  // phase view
  output logic [1:0] o_phase
);

  dps_pkg::dps_phase_t phase_r, phase_nxt;
  dps_pkg::dps_kind_t kind_r, tbl_kind;
  logic [7:0] cmd_r;
  logic [7:0] param_r [`DPS_MAX_PARAMS];
  logic [3:0] pcnt_r;
  logic [3:0] nparam_r;
  logic [2:0] nres_r;
  logic [2:0] rcnt_r;
  logic valid_r;
  logic rqm_r;
  logic [9:0] xfer_r;
  logic [7:0] rdata_r;
  logic dreq_r;
  logic start_r;
  logic wstb_r;
  logic [7:0] wdata_r;
  logic done_s1_r, done_s2_r;
  logic [3:0] tbl_nparam;
  logic [2:0] tbl_nres;
  logic tbl_valid;

  // the drive completion line is a pin: two flip-flops before any use
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
    end else begin
      done_s1_r <= i_drv_done;
      done_s2_r <= done_s1_r;
    end
  end

  // address decode, either address set answers
  wire sel_msr = (i_io_addr == `DPS_MAIN_STATUS_PRI) || (i_io_addr == `DPS_MAIN_STATUS_SEC);
  wire sel_data = (i_io_addr == `DPS_DATA_PRI) || (i_io_addr == `DPS_DATA_SEC);
  wire dma_on = (phase_r == dps_pkg::DPS_EXEC) && kind_r[1];
  wire dma_beat = dma_on && dreq_r && !i_dma_ack_ch_two_n && (i_io_rd || i_io_wr);
  // during a dma beat the strobes belong to the dma cycle, not to the ports
  wire host_wr = i_io_wr && sel_data && !dma_beat;
  wire host_rd = i_io_rd && sel_data && !dma_beat;
  wire accepts_byte = (phase_r == dps_pkg::DPS_IDLE) || (phase_r == dps_pkg::DPS_CMD);
  wire byte_in = host_wr && rqm_r && accepts_byte;
  wire byte_out = host_rd && rqm_r && (phase_r == dps_pkg::DPS_RES);
  wire first_byte = byte_in && (phase_r == dps_pkg::DPS_IDLE);

  // the table sees the incoming byte on the first write, the held code afterwards
  wire [7:0] code_now = first_byte ? i_io_wdata : cmd_r;

  dps_cmd_table u_table (
    .i_code(code_now),
    .o_nparam(tbl_nparam),
    .o_nres(tbl_nres),
    .o_kind(tbl_kind),
    .o_valid(tbl_valid)
  );

  wire params_full = first_byte ? (tbl_nparam == 4'h0) : (byte_in && (pcnt_r + 4'h1 == nparam_r));
  wire last_dma = dma_beat && (xfer_r == 10'd1);
  wire exec_done = (phase_r == dps_pkg::DPS_EXEC) &&
                   ((kind_r == dps_pkg::DPS_K_INTERNAL) ||
                    ((kind_r == dps_pkg::DPS_K_MECH) && done_s2_r && !start_r) ||
                    (kind_r[1] && last_dma));
  wire last_res = byte_out && (rcnt_r + 3'h1 == nres_r);

  // phase sequence: command, execution, results, never skipping back
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      dps_pkg::DPS_IDLE: begin
        if (first_byte && params_full) begin
          phase_nxt = dps_pkg::DPS_EXEC;
        end else if (first_byte) begin
          phase_nxt = dps_pkg::DPS_CMD;
        end
      end
      dps_pkg::DPS_CMD: begin
        if (params_full) begin
          phase_nxt = dps_pkg::DPS_EXEC;
        end
      end
      dps_pkg::DPS_EXEC: begin
        if (exec_done && (nres_r == 3'h0)) begin
          phase_nxt = dps_pkg::DPS_IDLE;
        end else if (exec_done) begin
          phase_nxt = dps_pkg::DPS_RES;
        end
      end
      dps_pkg::DPS_RES: begin
        if (last_res) begin
          phase_nxt = dps_pkg::DPS_IDLE;
        end
      end
      default: phase_nxt = dps_pkg::DPS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      phase_r <= dps_pkg::DPS_IDLE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  // command code and its decoded shape, caught with the first byte
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cmd_r <= 8'h00;
      nparam_r <= 4'h0;
      nres_r <= 3'h0;
      kind_r <= dps_pkg::DPS_K_INTERNAL;
      valid_r <= 1'b1;
    end else if (first_byte) begin
      cmd_r <= i_io_wdata;
      nparam_r <= tbl_nparam;
      nres_r <= tbl_nres;
      kind_r <= tbl_kind;
      valid_r <= tbl_valid;
    end
  end

  // parameter store and counters
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pcnt_r <= 4'h0;
    end else if (first_byte) begin
      pcnt_r <= 4'h0;
    end else if (byte_in) begin
      pcnt_r <= pcnt_r + 4'h1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `DPS_MAX_PARAMS; gi++) begin : g_param
      always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
          param_r[gi] <= 8'h00;
        end else if (byte_in && !first_byte && (pcnt_r == 4'(gi))) begin
          param_r[gi] <= i_io_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rcnt_r <= 3'h0;
    end else if (phase_r != dps_pkg::DPS_RES) begin
      rcnt_r <= 3'h0;
    end else if (byte_out) begin
      rcnt_r <= rcnt_r + 3'h1;
    end
  end

  // request for master: drops after each byte, for one cycle unless execution follows, so the host must poll
  wire rqm_nxt = !(byte_in || byte_out) &&
                 ((phase_nxt == dps_pkg::DPS_IDLE) || (phase_nxt == dps_pkg::DPS_CMD) ||
                  (phase_nxt == dps_pkg::DPS_RES));

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rqm_r <= 1'b1;
    end else begin
      rqm_r <= rqm_nxt;
    end
  end

  // result byte: first is status, the rest echo the parameters
  wire [7:0] res_byte = (rcnt_r == 3'h0) ? (valid_r ? `DPS_ST_OK : `DPS_ST_INVALID)
                                         : param_r[rcnt_r - 3'h1];
  wire [7:0] msr_byte = {rqm_r, (phase_r == dps_pkg::DPS_RES), 1'b0,
                         (phase_r != dps_pkg::DPS_IDLE), 4'h0};
  wire [7:0] rd_sel = sel_msr ? msr_byte : (byte_out ? res_byte : `DPS_RDATA_RESET);

  // read data is registered: it appears one cycle after the read strobe
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= `DPS_RDATA_RESET;
    end else if (dma_beat && (kind_r == dps_pkg::DPS_K_DMA_RD)) begin
      rdata_r <= i_drv_rdata;
    end else if (i_io_rd) begin
      rdata_r <= rd_sel;
    end
  end

  // dma channel two: request held until the last byte of the transfer
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      xfer_r <= 10'd0;
      dreq_r <= 1'b0;
    end else if ((phase_r != dps_pkg::DPS_EXEC) && (phase_nxt == dps_pkg::DPS_EXEC) &&
                 code_is_dma(tbl_kind, kind_r, first_byte)) begin
      xfer_r <= `DPS_XFER_BYTES;
      dreq_r <= 1'b1;
    end else if (dma_beat) begin
      xfer_r <= xfer_r - 10'd1;
      dreq_r <= !last_dma;
    end
  end

  function automatic logic code_is_dma(input dps_pkg::dps_kind_t k_new,
                                       input dps_pkg::dps_kind_t k_held,
                                       input logic use_new);
    code_is_dma = use_new ? k_new[1] : k_held[1];
  endfunction

  // drive side: a start pulse for mechanical work, write bytes to the drive
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      start_r <= 1'b0;
      wstb_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      start_r <= (phase_r != dps_pkg::DPS_EXEC) && (phase_nxt == dps_pkg::DPS_EXEC) &&
                 ((first_byte ? tbl_kind : kind_r) == dps_pkg::DPS_K_MECH);
      wstb_r <= dma_beat && (kind_r == dps_pkg::DPS_K_DMA_WR);
      if (dma_beat && (kind_r == dps_pkg::DPS_K_DMA_WR)) begin
        wdata_r <= i_io_wdata;
      end
    end
  end

  assign o_io_rdata = rdata_r;
  assign o_dma_request_ch_two = dreq_r;
  assign o_drv_start = start_r;
  assign o_drv_wstrobe = wstb_r;
  assign o_drv_wdata = wdata_r;
  assign o_phase = phase_r;

endmodule // dps_phase_seq

/* bench/dps_phase_seq_monitor.sv */
// concurrent checks on the phase sequencer ports
`timescale 1ns/1ps
`include "dps_defs.svh"
module dps_phase_seq_monitor (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // host io port
  input wire logic [15:0] i_io_addr,
  input wire logic i_io_wr,
  input wire logic i_io_rd,
  input wire logic [7:0] i_io_wdata,
  input wire logic [7:0] o_io_rdata,
  // dma
  input wire logic o_dma_request_ch_two,
  input wire logic i_dma_ack_ch_two_n,
  // drive side
  input wire logic o_drv_start,
  input wire logic o_drv_wstrobe,
  input wire logic [7:0] o_drv_wdata,
  input wire logic [7:0] i_drv_rdata,
  input wire logic i_drv_done,
  input wire logic [1:0] o_phase
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire is_data = i_io_addr == `DPS_DATA_PRI || i_io_addr == `DPS_DATA_SEC;
  wire is_msr = i_io_addr == `DPS_MAIN_STATUS_PRI || i_io_addr == `DPS_MAIN_STATUS_SEC;
  wire beat = o_dma_request_ch_two && !i_dma_ack_ch_two_n;
  // codes with parameters open the command phase, the rest go straight to execution
  wire has_params = i_io_wdata[4:0] == `DPS_OP_SPECIFY ||
    i_io_wdata[4:0] == `DPS_OP_SENSE_DRIVE || i_io_wdata[4:0] == `DPS_OP_WRITE_DATA ||
    i_io_wdata[4:0] == `DPS_OP_READ_DATA || i_io_wdata[4:0] == `DPS_OP_RECAL ||
    i_io_wdata[4:0] == `DPS_OP_SEEK;
  a_phase_order: assert property ($changed(o_phase) |-> {$past(o_phase), o_phase} inside
    {4'b0001, 4'b0011, 4'b0111, 4'b1110, 4'b1100, 4'b1000}) else $error("illegal phase step");
  a_idle_stays: assert property (o_phase == 2'b00 && !(i_io_wr && is_data) |=>
    o_phase == 2'b00) else $error("left idle without a byte");
  a_first_byte: assert property (o_phase == 2'b00 && $past(o_phase) == 2'b00 && i_io_wr &&
    is_data |=> o_phase == ($past(has_params) ? 2'b01 : 2'b11))
    else $error("first byte did not open the right phase");
  a_status_bits: assert property (i_io_rd && is_msr && !beat |=> o_io_rdata[5:0] ==
    {1'b0, $past(o_phase) != 2'b00, 4'h0} && o_io_rdata[6] == ($past(o_phase) == 2'b10))
    else $error("main status fields wrong");
  a_req_in_exec: assert property (o_dma_request_ch_two |-> o_phase == 2'b11)
    else $error("dma request outside execution");
  a_req_to_res: assert property ($fell(o_dma_request_ch_two) |-> o_phase == 2'b10)
    else $error("dma end not followed by results");
  a_rd_beat: assert property (beat && i_io_rd |=> o_io_rdata == $past(i_drv_rdata))
    else $error("dma read beat data wrong");
  a_wr_beat: assert property (beat && i_io_wr |=> o_drv_wstrobe &&
    o_drv_wdata == $past(i_io_wdata)) else $error("dma write beat lost");
  a_wstrobe_cause: assert property (o_drv_wstrobe |-> $past(beat && i_io_wr))
    else $error("drive strobe without beat");
  a_start_pulse: assert property (o_drv_start |-> o_phase == 2'b11 ##1 !o_drv_start)
    else $error("start pulse wrong");
  a_res_holds: assert property (o_phase == 2'b10 && !i_io_rd |=> o_phase == 2'b10)
    else $error("results left without a read");
endmodule // dps_phase_seq_monitor
bind dps_phase_seq dps_phase_seq_monitor i_mon (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_io_addr(i_io_addr), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd), .i_io_wdata(i_io_wdata),
  .o_io_rdata(o_io_rdata), .o_dma_request_ch_two(o_dma_request_ch_two),
  .i_dma_ack_ch_two_n(i_dma_ack_ch_two_n), .o_drv_start(o_drv_start),
  .o_drv_wstrobe(o_drv_wstrobe), .o_drv_wdata(o_drv_wdata), .i_drv_rdata(i_drv_rdata),
  .i_drv_done(i_drv_done), .o_phase(o_phase));

/* bench/dps_drive_model.sv */
// drive stand-in: read data that changes every cycle, done high for five cycles after a seek delay
`timescale 1ns/1ps
module dps_drive_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // drive side
  input wire logic i_start,
  output logic [7:0] o_rdata,
  output logic o_done
);
  logic [4:0] cnt_r;
  logic [7:0] rdata_r;
  // data keeps moving so a stale capture cannot match by luck
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_r <= 8'h5A;
      cnt_r <= 5'h00;
    end else begin
      rdata_r <= rdata_r + 8'h3B;
      cnt_r <= i_start ? 5'h01 : (cnt_r != 5'h00 ? cnt_r + 5'h01 : 5'h00);
    end
  end
  assign o_rdata = rdata_r;
  assign o_done = cnt_r >= 5'h14 && cnt_r <= 5'h18;
endmodule // dps_drive_model

/* bench/dps_phase_seq_bench.sv */
// command table walk through all phases of the sequencer
`timescale 1ns/1ps
`include "dps_defs.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module dps_phase_seq_bench;
  logic mclk = 0, rst = 1, io_wr = 0, io_rd = 0, dack_n = 1, dreq, start, wstb, done;
  logic [15:0] io_addr = 16'h0000;
  logic [7:0] io_wdata = 8'h00, rdata, wdata, drdata;
  logic [1:0] phase;
  int n_mismatch = 0, tests_run = 0;
  dps_phase_seq i_dut (.i_mclk(mclk), .i_rst(rst), .i_io_addr(io_addr), .i_io_wr(io_wr),
    .i_io_rd(io_rd), .i_io_wdata(io_wdata), .o_io_rdata(rdata), .o_dma_request_ch_two(dreq),
    .i_dma_ack_ch_two_n(dack_n), .o_drv_start(start), .o_drv_wstrobe(wstb),
    .o_drv_wdata(wdata), .i_drv_rdata(drdata), .i_drv_done(done), .o_phase(phase));
  dps_drive_model i_drv (.i_mclk(mclk), .i_rst(rst), .i_start(start), .o_rdata(drdata),
    .o_done(done));
  initial begin
    forever #2.5 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic io(input logic [15:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    io_addr = a;
    io_wdata = d;
    io_wr = w;
    io_rd = !w;
    @(posedge mclk);
    #1 io_wr = 0;
    io_rd = 0;
    @(posedge mclk);
    #1 q = rdata;
  endtask
  // host waits on ready before every byte either way
  task automatic poll(input logic [15:0] a, input logic res);
    logic [7:0] q;
    int i;
    for (i = 0; i < 300; i++) begin
      io(a, 1'b0, 8'h00, q);
      if (q[7] === 1'b1) break;
    end
    if (i == 300) begin
      n_mismatch++;
      $display("[FAIL] %0t ready never came", $time);
      finish_test();
    end
    `CHK(q[6], res)
  endtask
  task automatic wait_for(input logic want_req);
    int i;
    // look just after each edge, never in the time step that launches the outputs
    for (i = 0; i < 2000 && (want_req ? dreq !== 1'b1 : phase !== 2'b00); i++) begin
      @(posedge mclk);
      #1;
    end
    if (i == 2000) begin
      n_mismatch++;
      $display("[FAIL] %0t wait ran out", $time);
      finish_test();
    end
  endtask
  // k: 0 internal, 1 mechanical, 2 dma read, 3 dma write, 4 unknown code
  task automatic run_cmd(input logic [7:0] c, input int np, input int nr, input int k);
    logic [7:0] q;
    int i, n;
    poll(`DPS_MAIN_STATUS_PRI, 1'b0);
    io(`DPS_DATA_PRI, 1'b1, c, q);
    for (i = 0; i < np; i++) begin
      poll(`DPS_MAIN_STATUS_SEC, 1'b0);
      io(`DPS_DATA_SEC, 1'b1, 8'h10 + 8'(i), q);
    end
    if (k == 2 || k == 3) begin
      wait_for(1'b1);
      `CHK(phase, 2'b11)
      dack_n = 0;
      io_rd = k == 2;
      io_wr = k == 3;
      for (n = 0; dreq === 1'b1 && n < 600; n++) begin
        @(posedge mclk);
        #1 io_wdata = 8'(n + 1);
      end
      // release, then let an edge pass before the host strobes again
      dack_n = 1;
      io_rd = 0;
      io_wr = 0;
      @(posedge mclk);
      #1 `CHK(n, 512)
    end
    for (i = 0; i < nr; i++) begin
      poll(`DPS_MAIN_STATUS_PRI, 1'b1);
      io(`DPS_DATA_PRI, 1'b0, 8'h00, q);
      if (i == 0) `CHK(q, k == 4 ? `DPS_ST_INVALID : `DPS_ST_OK)
      else if (i <= np) `CHK(q, 8'h10 + 8'(i - 1))
    end
    wait_for(1'b0);
    `CHK(phase, 2'b00)
    io(`DPS_MAIN_STATUS_PRI, 1'b0, 8'h00, q);
    `CHK(q, 8'h80)
  endtask
  logic [7:0] codes [8] = '{8'h03, 8'h04, 8'h08, 8'h1F, 8'h0F, 8'h07, 8'h46, 8'hC5};
  int nps [8] = '{2, 1, 0, 0, 2, 1, 8, 8};
  int nrs [8] = '{0, 1, 2, 1, 0, 0, 7, 7};
  int kinds [8] = '{0, 0, 0, 4, 1, 1, 2, 3};
  initial begin
    logic [7:0] q;
    repeat (2) @(posedge mclk);
    #1 rst = 0;
    `CHK(phase, 2'b00)
    io(`DPS_MAIN_STATUS_SEC, 1'b0, 8'h00, q);
    `CHK(q, 8'h80)
    // each code twice: back to back commands must reopen cleanly
    for (int t = 0; t < 16; t++) begin
      run_cmd(codes[t % 8], nps[t % 8], nrs[t % 8], kinds[t % 8]);
      $display("test %0d code %h done", t, codes[t % 8]);
    end
    finish_test();
  end
endmodule // dps_phase_seq_bench
